/* File: hw/sbo_pkg.sv */
// Notes on behaviour
// - Register op: result = R + ~ACC + C, R address 0..63, updates Z, DC, C.
// - Register op with destination bit 0 writes accumulator, register untouched.
// - Register op with destination bit 1 writes result back to register.
// - Immediate op: result = imm + ~ACC + C, updates Z, DC, C.
// - Immediate op always writes accumulator, completes in one cycle.
// - Aux page read copies aux register 0..15 to accumulator, flags untouched.
// - Aux page write loads indexed aux register from accumulator.
package sbo_pkg;
  localparam int DATA_W = 8;
  localparam int REG_ADDR_W = 6;
  localparam int AUX_ADDR_W = 4;
  localparam int AUX_DEPTH = 16;
  localparam int NIBBLE_MSB = 3;
  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

  typedef enum logic [2:0] {
    SBO_OP_NONE,
    SBO_OP_REG_SUB,
    SBO_OP_IMM_SUB,
    SBO_OP_AUX_READ,
    SBO_OP_AUX_WRITE
  } sbo_op_e;

  typedef struct packed {
    logic z;
    logic dc;
    logic c;
  } sbo_flags_s;

  typedef struct packed {
    sbo_op_e op;
    logic dest;
    logic [REG_ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_data;
    logic [DATA_W-1:0] imm;
    logic [AUX_ADDR_W-1:0] aux_addr;
  } sbo_cmd_s;
endpackage : sbo_pkg

/* File: hw/sbo_aux_page.sv */
`timescale 1ns/1ns
`default_nettype none
module sbo_aux_page
  import sbo_pkg::*;
#(
  parameter int WIDTH = DATA_W,
  parameter int DEPTH = AUX_DEPTH,
  parameter int AW = AUX_ADDR_W
) (
  input wire logic clk,
  input wire logic ce,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  initial begin
    if (DEPTH > (1 << AW)) $error("sbo_aux_page: depth exceeds address");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  // Read data registered; caller accounts for the one-cycle latency
  always_ff @(posedge clk) begin
    if (ce) begin
      if (we) begin
        mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
    end
  end
endmodule : sbo_aux_page
`default_nettype wire

/* File: hw/sbo_datapath.sv */
`timescale 1ns/1ns
`default_nettype none
module sbo_datapath
  import sbo_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic CMD_VALID,
  input wire sbo_cmd_s CMD,
  input wire sbo_flags_s FLAGS_IN,
  output logic [DATA_W-1:0] ACC,
  output sbo_flags_s FLAGS,
  output logic FLAGS_WE,
  output logic REG_WE,
  output logic [REG_ADDR_W-1:0] REG_WADDR,
  output logic [DATA_W-1:0] REG_WDATA,
  output logic DONE
);
  logic [DATA_W-1:0] acc;
  logic [DATA_W-1:0] next_acc;
  sbo_flags_s flags;
  sbo_flags_s next_flags;
  logic flags_we;
  logic next_flags_we;
  logic reg_we;
  logic next_reg_we;
  logic [REG_ADDR_W-1:0] reg_waddr;
  logic [REG_ADDR_W-1:0] next_reg_waddr;
  logic [DATA_W-1:0] reg_wdata;
  logic [DATA_W-1:0] next_reg_wdata;
  logic done;
  logic next_done;
  logic aux_pending;
  logic next_aux_pending;
  logic [DATA_W-1:0] aux_rdata;
  logic aux_we;

  logic [DATA_W-1:0] opnd;
  logic [NIBBLE_MSB+1:0] low_sum;
  logic [DATA_W:0] full_sum;
  logic cin;
  logic is_sub;

  assign aux_we = CE && CMD_VALID && CMD.op == SBO_OP_AUX_WRITE;

  // Write port takes the accumulator as it stands when the op issues
  sbo_aux_page u_aux (
    .clk(CLK),
    .ce(CE),
    .we(aux_we),
    .waddr(CMD.aux_addr),
    .wdata(acc),
    .raddr(CMD.aux_addr),
    .rdata(aux_rdata)
  );

  always_comb begin
    is_sub = CMD.op == SBO_OP_REG_SUB || CMD.op == SBO_OP_IMM_SUB;
    opnd = (CMD.op == SBO_OP_IMM_SUB) ? CMD.imm : CMD.reg_data;
    cin = FLAGS_IN.c;
    // Separate 5-bit low-nibble add exposes the nibble carry beside the full add
    low_sum = {1'b0, opnd[NIBBLE_MSB:0]} + {1'b0, ~acc[NIBBLE_MSB:0]}
      + {{NIBBLE_MSB+1{1'b0}}, cin};
    full_sum = {1'b0, opnd} + {1'b0, ~acc} + {{DATA_W{1'b0}}, cin};
  end

  always_comb begin
    next_acc = acc;
    next_flags = flags;
    next_flags_we = 1'b0;
    next_reg_we = 1'b0;
    next_reg_waddr = reg_waddr;
    next_reg_wdata = reg_wdata;
    next_done = 1'b0;
    next_aux_pending = 1'b0;
    // Aux read data lands one cycle later from the memory register
    if (aux_pending) begin
      next_acc = aux_rdata;
    end
    if (CMD_VALID) begin
      next_done = 1'b1;
      if (is_sub) begin
        next_flags.c = full_sum[DATA_W];
        next_flags.dc = low_sum[NIBBLE_MSB+1];
        next_flags.z = full_sum[DATA_W-1:0] == ZERO_BYTE;
        next_flags_we = 1'b1;
      end
      unique case (CMD.op)
        SBO_OP_REG_SUB: begin
          if (CMD.dest) begin
            next_reg_we = 1'b1;
            next_reg_waddr = CMD.reg_addr;
            next_reg_wdata = full_sum[DATA_W-1:0];
          end else begin
            next_acc = full_sum[DATA_W-1:0];
          end
        end
        SBO_OP_IMM_SUB: next_acc = full_sum[DATA_W-1:0];
        SBO_OP_AUX_READ: next_aux_pending = 1'b1;
        SBO_OP_AUX_WRITE, SBO_OP_NONE: next_done = CMD.op != SBO_OP_NONE;
        default: next_done = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      acc <= ACC_RESET;
      flags <= '0;
      flags_we <= 1'b0;
      reg_we <= 1'b0;
      reg_waddr <= '0;
      reg_wdata <= ZERO_BYTE;
      done <= 1'b0;
      aux_pending <= 1'b0;
    end else if (CE) begin
      acc <= next_acc;
      flags <= next_flags;
      flags_we <= next_flags_we;
      reg_we <= next_reg_we;
      reg_waddr <= next_reg_waddr;
      reg_wdata <= next_reg_wdata;
      done <= next_done;
      aux_pending <= next_aux_pending;
    end
  end

  assign ACC = acc;
  assign FLAGS = flags;
  assign FLAGS_WE = flags_we;
  assign REG_WE = reg_we;
  assign REG_WADDR = reg_waddr;
  assign REG_WDATA = reg_wdata;
  assign DONE = done;
endmodule : sbo_datapath
`default_nettype wire

/* File: tb/sbo_datapath_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module sbo_datapath_monitor
  import sbo_pkg::*;
(
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic CE,
  input wire logic CMD_VALID,
  input wire sbo_cmd_s CMD,
  input wire sbo_flags_s FLAGS_IN,
  input wire logic [DATA_W-1:0] ACC,
  input wire sbo_flags_s FLAGS,
  input wire logic FLAGS_WE,
  input wire logic REG_WE,
  input wire logic [REG_ADDR_W-1:0] REG_WADDR,
  input wire logic [DATA_W-1:0] REG_WDATA,
  input wire logic DONE
);
  wire go = CE && CMD_VALID;
  wire rs = go && CMD.op == SBO_OP_REG_SUB;
  wire ims = go && CMD.op == SBO_OP_IMM_SUB;
  wire [7:0] b = ims ? CMD.imm : CMD.reg_data;
  wire [8:0] s = {1'b0, b} + {1'b0, ~ACC} + FLAGS_IN.c;
  wire [4:0] h = {1'b0, b[3:0]} + {1'b0, ~ACC[3:0]} + FLAGS_IN.c;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  chk_carry_zero: assert property (rs || ims |=> FLAGS_WE &&
    FLAGS.c == $past(s[8]) && FLAGS.z == !$past(s[7:0])) else $error("cz");
  chk_dc_flag: assert property (rs || ims |=>
    FLAGS.dc == $past(h[4])) else $error("dc");
  chk_reg_acc: assert property (rs && !CMD.dest |=>
    !REG_WE && ACC == $past(s[7:0])) else $error("racc");
  chk_reg_back: assert property (rs && CMD.dest |=> REG_WE &&
    REG_WDATA == $past(s[7:0]) && REG_WADDR == $past(CMD.reg_addr)
    && $stable(ACC)) else $error("rback");
  chk_imm_acc: assert property (ims |=> DONE && !REG_WE &&
    ACC == $past(s[7:0])) else $error("imm");
  chk_aux_read: assert property (go && CMD.op == SBO_OP_AUX_READ |=>
    DONE && !FLAGS_WE && !REG_WE && $stable(FLAGS)) else $error("ard");
  chk_aux_write: assert property (go && CMD.op == SBO_OP_AUX_WRITE |=>
    DONE && !FLAGS_WE && !REG_WE) else $error("awr");
  chk_idle_quiet: assert property (CE && !CMD_VALID |=>
    !DONE && !FLAGS_WE && !REG_WE) else $error("idle");
endmodule : sbo_datapath_monitor
bind sbo_datapath sbo_datapath_monitor u_mon (.*);
`default_nettype wire

/* File: tb/sbo_rf_model.sv */
`timescale 1ns/1ns
`default_nettype none
module sbo_rf_model
  import sbo_pkg::*;
(
  input wire logic clk,
  input wire logic we,
  input wire logic [REG_ADDR_W-1:0] wa,
  input wire logic [DATA_W-1:0] wd,
  input wire logic [REG_ADDR_W-1:0] ra,
  output logic [DATA_W-1:0] rd
);
  logic [DATA_W-1:0] m [64];
  // Contents arbitrary; index pattern makes R predictable
  initial for (int i = 0; i < 64; i++) m[i] = 8'(i);
  always @(posedge clk) if (we) m[wa] <= wd;
  assign rd = m[ra];
endmodule : sbo_rf_model
`default_nettype wire

/* File: tb/subtract_borrow_sfr_read_ops_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module subtract_borrow_sfr_read_ops_tb_top import sbo_pkg::*;;
  logic clk = 0, rst = 1, ce = 1, vld = 0, fwe, rwe, done;
  sbo_cmd_s cmd = '0;
  sbo_flags_s fin = '0, fl;
  logic [7:0] acc, rd, wdat;
  logic [5:0] wadr;
  int errors = 0, checks_done = 0;
  // op d addr imm c flags result; ACC chains from row to row
  logic [39:0] rows [9] = '{40'h2000070306, 40'h11050000FE, 40'h113F001339,
    40'h20000510FF, 40'h2000050005, 40'h1006000700, 40'h2000060305,
    40'h1106001301, 40'h2000060700};
  always #5 clk = ~clk;
  sbo_datapath u_dut (.CLK(clk), .SYS_RST(rst), .CE(ce), .CMD_VALID(vld),
    .CMD({cmd.op, cmd.dest, cmd.reg_addr, rd, cmd.imm, cmd.aux_addr}),
    .FLAGS_IN(fin), .ACC(acc), .FLAGS(fl), .FLAGS_WE(fwe), .REG_WE(rwe),
    .REG_WADDR(wadr), .REG_WDATA(wdat), .DONE(done));
  sbo_rf_model u_rf (.clk(clk), .we(rwe), .wa(wadr), .wd(wdat),
    .ra(cmd.reg_addr), .rd(rd));
  task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk
  task automatic issue(input sbo_op_e op, input logic [7:0] v,
    input logic [5:0] a, input logic d, input logic c);
    cmd = '{op, d, a, '0, v, a[3:0]};
    fin.c = c;
    vld = 1;
    @(posedge clk) #1;
  endtask : issue
  task automatic results;
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  initial begin
    repeat (10) @(posedge clk);
    #1 rst = 0;
    for (int i = 0; i < 9; i++) begin
      logic [39:0] r;
      r = rows[i];
      issue(sbo_op_e'(r[39:36]), r[23:16], r[29:24], r[32], r[12]);
      chk({4'h0, done, fwe, fl}, {6'h03, r[10:8]});
      chk({rwe, r[32] ? wdat : acc}, {r[32], r[7:0]});
      if (r[32]) chk({3'h0, wadr}, {3'h0, r[29:24]});
    end
    issue(SBO_OP_IMM_SUB, 8'h5B, '0, '0, '0);
    issue(SBO_OP_AUX_WRITE, '0, 6'h0F, '0, '0);
    issue(SBO_OP_IMM_SUB, '0, '0, '0, '1);
    issue(SBO_OP_AUX_READ, '0, 6'h0F, '0, '0);
    vld = 0;
    chk({4'h0, done, fwe, fl}, 9'h010);
    @(posedge clk) #1 chk({1'b0, acc}, 9'h05A);
    ce = 0;
    issue(SBO_OP_IMM_SUB, 8'h11, '0, '0, '0);
    chk({done, acc}, 9'h05A);
    ce = 1;
    issue(SBO_OP_NONE, '0, '0, '0, '0);
    vld = 0;
    chk({done, acc}, 9'h05A);
    rst = 1;
    @(posedge clk) #1 rst = 0;
    chk({done, acc}, 9'h000);
    results();
  end
endmodule : subtract_borrow_sfr_read_ops_tb_top
`default_nettype wire
